// ==== common/usb_irq_map.svh ====
// register offsets, field positions and reset values of the usb interrupt and endpoint list block
// Summary of operation
// - irq only when enable and pending both set
// - writing one to set register sets pending
// - set register reads back the pending register
// - per-source line select: 0 normal, 1 fast
// - read-only ten-bit per-endpoint data toggle field
// - endpoint entries fetched from list base address
// - list order ep0 out/in, then ep1-4
// - active 31, stall 29, toggle reset 28, value 27
// - bits 25:16 byte count, 15:0 offset
// - second ep0 word holds setup buffer offset
// - ep1-4 disable bit 30, type bit 26
// - ep1-4 directions have two alternating buffers
// - hardware only clears active: short, zero, skip
// - disabled endpoint token ignored, no data, no handshake
// - stall only when inactive and stall set
// - pending bits cleared by writing one
`ifndef USB_IRQ_MAP_SVH
`define USB_IRQ_MAP_SVH
`define USB_PENDING_ADDR   32'h40080020
`define USB_ENABLE_ADDR    32'h40080024
`define USB_SET_ADDR       32'h40080028
`define USB_LINE_SEL_ADDR  32'h4008002c
`define USB_TOGGLE_ADDR    32'h40080034
`define USB_LIST_BASE_ADDR 32'h40080040
`define USB_REG_RESET      32'h00000000
`define USB_SRC_MASK       32'hc00003ff
`define USB_EP_LO          0
`define USB_EP_HI          9
`define USB_SOF_BIT        30
`define USB_DEV_BIT        31
`define ENT_ACTIVE         31
`define ENT_DISABLE        30
`define ENT_STALL          29
`define ENT_TRST           28
`define ENT_TVAL           27
`define ENT_TYPE           26
`define ENT_CNT_HI         25
`define ENT_CNT_LO         16
`define ENT_OFS_HI         15
`define ENT_OFS_LO         0
`define SETUP_WORD_IDX     5'h01
`endif

// ==== common/usb_irq_pkg.sv ====
// types shared by the usb interrupt and endpoint list block
package usb_irq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EVAL = 2'b10,
    ST_WRITE = 2'b11
  } list_state_e;
  typedef enum logic [1:0] {
    RESP_IGNORE = 2'b00,
    RESP_STALL  = 2'b01,
    RESP_NAK    = 2'b10,
    RESP_DATA   = 2'b11
  } token_resp_e;
endpackage

// ==== rtl/usb_dev_irq_and_ep_list.sv ====
// usb device interrupt enable, set, routing, toggle readback and endpoint list engine
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "usb_irq_map.svh"
module usb_dev_irq_and_ep_list (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        xfer_req,
  input  wire logic [2:0]  xfer_ep,
  input  wire logic        xfer_in,
  input  wire logic [9:0]  xfer_len,
  input  wire logic        xfer_short,
  input  wire logic [9:0]  skip_req,
  input  wire logic        sof_event,
  input  wire logic        device_event,
  output logic             xfer_busy,
  output logic             resp_valid,
  output logic      [1:0]  resp_code,
  output logic      [15:0] resp_offset,
  output logic      [9:0]  resp_count,
  output logic             resp_toggle,
  output logic             resp_buffer,
  output logic             irq_normal,
  output logic             fast_interrupt_line
);

  // software visible state
  logic [31:0] pending_q;         // usb_irq_pending
  logic [31:0] enable_q;          // usb_irq_enable
  logic [31:0] line_sel_q;        // usb_irq_line_select
  logic [31:0] list_base_q;       // endpoint list base, word aligned
  logic [9:0]  toggle_q;          // per physical endpoint data toggle
  logic [9:0]  buf_sel_q;         // alternating buffer per physical endpoint
  logic [9:0]  skip_pend_q;       // skips waiting for the list engine

  // list engine state
  usb_irq_pkg::list_state_e state_q;
  logic [3:0]  cur_p_q;           // physical endpoint index, 2*ep + dir
  logic        cur_skip_q;        // job is a skip rather than a token
  logic [9:0]  cur_len_q;         // bytes moved by the reported packet
  logic        cur_short_q;       // packet was short
  logic [31:0] entry_q;           // fetched list word

  // bus decode
  logic        bus_acc;           // access phase, first cycle
  logic        bus_wr;
  logic        addr_ok;
  logic [31:0] rd_val;

  // engine decode
  logic [9:0]  hw_set;            // endpoint pending set by the engine
  logic [9:0]  skip_all;
  logic [3:0]  skip_idx;
  logic        skip_any;
  logic [4:0]  word_idx;
  logic [31:0] word_addr;
  logic        is_ep0;
  logic        ent_dis;
  logic        ent_act;
  logic        ent_stall;
  logic [9:0]  ent_cnt;
  logic [15:0] ent_ofs;
  logic [9:0]  rem_cnt;
  logic        done;
  logic        cur_tog;
  logic [31:0] new_entry;
  usb_irq_pkg::token_resp_e eval_code;

  // pready rises one cycle into the access phase, so every access takes three cycles, setup included
  assign bus_acc = psel & penable & ~pready;
  // writes land only at the edge that completes the transfer, never a cycle early
  assign bus_wr  = psel & penable & pready & pwrite & addr_ok;

  // address decode and read mux; reserved bits come back as zero
  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 32'h00000000;
    case (paddr)
      `USB_PENDING_ADDR:   rd_val = pending_q;
      `USB_ENABLE_ADDR:    rd_val = enable_q;
      `USB_SET_ADDR:       rd_val = pending_q;
      `USB_LINE_SEL_ADDR:  rd_val = line_sel_q;
      `USB_TOGGLE_ADDR:    rd_val = {22'h000000, toggle_q};
      `USB_LIST_BASE_ADDR: rd_val = list_base_q;
      default:             addr_ok = 1'b0;
    endcase
  end

  // apb answer registers; unmapped addresses end with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= bus_acc;
      pslverr <= bus_acc & ~addr_ok;
      if (bus_acc & ~pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // enable register, only source bits are writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `USB_REG_RESET;
    end else if (bus_wr && paddr == `USB_ENABLE_ADDR) begin
      enable_q <= pwdata & `USB_SRC_MASK;
    end
  end

  // line select register, one bit per source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sel_q <= `USB_REG_RESET;
    end else if (bus_wr && paddr == `USB_LINE_SEL_ADDR) begin
      line_sel_q <= pwdata & `USB_SRC_MASK;
    end
  end

  // list base register; low two bits forced to zero to keep fetches aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      list_base_q <= `USB_REG_RESET;
    end else if (bus_wr && paddr == `USB_LIST_BASE_ADDR) begin
      list_base_q <= {pwdata[31:2], 2'b00};
    end
  end

  // pending register: set sources beat the write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= `USB_REG_RESET;
    end else begin
      logic [31:0] set_v;
      logic [31:0] clr_v;
      set_v = {device_event, sof_event, 20'h00000, hw_set};
      clr_v = 32'h00000000;
      if (bus_wr && paddr == `USB_SET_ADDR) begin
        set_v = set_v | (pwdata & `USB_SRC_MASK);
      end
      if (bus_wr && paddr == `USB_PENDING_ADDR) begin
        clr_v = pwdata & `USB_SRC_MASK;
      end
      pending_q <= ((pending_q & ~clr_v) | set_v) & `USB_SRC_MASK;
    end
  end

  // interrupt lines, registered so both outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_normal          <= 1'b0;
      fast_interrupt_line <= 1'b0;
    end else begin
      irq_normal          <= |(pending_q & enable_q & ~line_sel_q);
      fast_interrupt_line <= |(pending_q & enable_q & line_sel_q);
    end
  end

  // lowest numbered skip waiting; one skip served per engine pass
  always_comb begin
    skip_all = skip_pend_q | skip_req;
    skip_idx = 4'h0;
    skip_any = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (skip_pend_q[i]) begin
        skip_idx = i[3:0];
        skip_any = 1'b1;
      end
    end
  end

  // word position of the current physical endpoint in the list
  function automatic logic [4:0] list_word(input logic [3:0] p, input logic b);
    logic [2:0] ep;
    ep = p[3:1];
    if (ep == 3'h0) begin
      list_word = p[0] ? (`SETUP_WORD_IDX + 5'h01) : 5'h00;  // ep0 in past setup word
    end else begin
      list_word = {ep[2:0], 2'b00} + {2'b00, p[0], 1'b0} + {4'h0, b};
    end
  endfunction

  // decode of the fetched word and its write-back image
  always_comb begin
    is_ep0    = (cur_p_q[3:1] == 3'h0);
    ent_dis   = ~is_ep0 & entry_q[`ENT_DISABLE];  // ep0 has this bit reserved
    ent_act   = entry_q[`ENT_ACTIVE];
    ent_stall = entry_q[`ENT_STALL];
    ent_cnt   = entry_q[`ENT_CNT_HI:`ENT_CNT_LO];
    ent_ofs   = entry_q[`ENT_OFS_HI:`ENT_OFS_LO];
    rem_cnt   = (cur_len_q >= ent_cnt) ? 10'h000 : (ent_cnt - cur_len_q);
    done      = cur_skip_q | cur_short_q | (rem_cnt == 10'h000);
    // toggle reset flag loads the toggle value before the packet is sent
    cur_tog   = entry_q[`ENT_TRST] ? entry_q[`ENT_TVAL] : toggle_q[cur_p_q];
    new_entry = entry_q;
    new_entry[`ENT_TRST] = 1'b0;
    if (cur_skip_q) begin
      new_entry[`ENT_ACTIVE] = 1'b0;
    end else begin
      new_entry[`ENT_CNT_HI:`ENT_CNT_LO] = rem_cnt;
      new_entry[`ENT_OFS_HI:`ENT_OFS_LO] = ent_ofs + {6'h00, cur_len_q};
      // hardware only ever clears active, never sets it
      new_entry[`ENT_ACTIVE] = ent_act & ~done;
    end
    if (ent_dis) begin
      eval_code = usb_irq_pkg::RESP_IGNORE;
    end else if (ent_act) begin
      eval_code = usb_irq_pkg::RESP_DATA;
    end else if (ent_stall) begin
      eval_code = usb_irq_pkg::RESP_STALL;
    end else begin
      eval_code = usb_irq_pkg::RESP_NAK;
    end
    hw_set = 10'h000;
    if (state_q == usb_irq_pkg::ST_EVAL && ent_act && done && (cur_skip_q || !ent_dis)) begin
      hw_set[cur_p_q] = 1'b1;
    end
  end

  assign word_addr = list_base_q + {25'h0000000, word_idx, 2'b00};

  // word index of the next job, tokens before skips
  always_comb begin
    if (xfer_req) begin
      word_idx = list_word({xfer_ep, xfer_in}, buf_sel_q[{xfer_ep, xfer_in}]);
    end else begin
      word_idx = list_word(skip_idx, buf_sel_q[skip_idx]);
    end
  end

  // skip requests wait here until the engine takes the skip job from idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_pend_q <= 10'h000;
    end else begin
      logic [9:0] clr;
      clr = 10'h000;
      if (state_q == usb_irq_pkg::ST_IDLE && !xfer_req && skip_any) begin
        clr[skip_idx] = 1'b1;
      end
      skip_pend_q <= skip_all & ~(clr & ~skip_req);
    end
  end

  // list engine: fetch, evaluate, write back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= usb_irq_pkg::ST_IDLE;
      cur_p_q     <= 4'h0;
      cur_skip_q  <= 1'b0;
      cur_len_q   <= 10'h000;
      cur_short_q <= 1'b0;
      entry_q     <= 32'h00000000;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 32'h00000000;
      mem_wdata   <= 32'h00000000;
    end else begin
      case (state_q)
        usb_irq_pkg::ST_IDLE: begin
          // a token report is taken only while xfer_busy is low
          if (xfer_req || skip_any) begin
            cur_p_q     <= xfer_req ? {xfer_ep, xfer_in} : skip_idx;
            cur_skip_q  <= ~xfer_req;
            cur_len_q   <= xfer_req ? xfer_len : 10'h000;
            cur_short_q <= xfer_req & xfer_short;
            mem_req     <= 1'b1;
            mem_we      <= 1'b0;
            mem_addr    <= word_addr;
            state_q     <= usb_irq_pkg::ST_READ;
          end
        end
        usb_irq_pkg::ST_READ: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            entry_q <= mem_rdata;
            state_q <= usb_irq_pkg::ST_EVAL;
          end
        end
        usb_irq_pkg::ST_EVAL: begin
          // inactive entries, and disabled ones on a token report, are left untouched in memory
          if ((cur_skip_q && ent_act) || (!cur_skip_q && !ent_dis && ent_act)) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_wdata <= new_entry;
            state_q   <= usb_irq_pkg::ST_WRITE;
          end else begin
            state_q <= usb_irq_pkg::ST_IDLE;
          end
        end
        usb_irq_pkg::ST_WRITE: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state_q <= usb_irq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= usb_irq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // busy flag back to the packet engine, high from acceptance to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_busy <= 1'b0;
    end else begin
      xfer_busy <= (state_q == usb_irq_pkg::ST_IDLE) ? (xfer_req || skip_any)
                 : (state_q == usb_irq_pkg::ST_EVAL) ? (ent_act && (cur_skip_q || !ent_dis))
                 : (state_q != usb_irq_pkg::ST_WRITE || !mem_ack);
    end
  end

  // token answer, one cycle pulse when the fetched entry has been evaluated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid  <= 1'b0;
      resp_code   <= 2'b00;
      resp_offset <= 16'h0000;
      resp_count  <= 10'h000;
      resp_toggle <= 1'b0;
      resp_buffer <= 1'b0;
    end else begin
      resp_valid <= (state_q == usb_irq_pkg::ST_EVAL) && !cur_skip_q;
      if (state_q == usb_irq_pkg::ST_EVAL && !cur_skip_q) begin
        resp_code   <= eval_code;
        resp_offset <= ent_ofs;
        resp_count  <= ent_cnt;
        resp_toggle <= cur_tog;
        resp_buffer <= buf_sel_q[cur_p_q];
      end
    end
  end

  // toggle and buffer select update per physical endpoint
  for (genvar g = 0; g < 10; g++) begin : g_ep
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        toggle_q[g]  <= 1'b0;
        buf_sel_q[g] <= 1'b0;
      end else if (state_q == usb_irq_pkg::ST_EVAL && cur_p_q == 4'(g) && ent_act) begin
        // a data packet flips the toggle; a skip keeps it
        if (!cur_skip_q && !ent_dis) begin
          toggle_q[g] <= ~cur_tog;
        end
        // ep0 has a single buffer per direction
        if (g >= 2 && done && (cur_skip_q || !ent_dis)) begin
          buf_sel_q[g] <= ~buf_sel_q[g];
        end
      end
    end
  end

endmodule

// ==== tb/usb_dev_irq_and_ep_list_properties.sv ====
// port-level checks for the usb interrupt and endpoint list block
`timescale 1ns/1ps
`include "usb_irq_map.svh"
module usb_dev_irq_and_ep_list_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_ack,
  input wire logic        xfer_req,
  input wire logic        xfer_busy,
  input wire logic        resp_valid,
  input wire logic [1:0]  resp_code,
  input wire logic [15:0] resp_offset,
  input wire logic [9:0]  resp_count
);
  logic [31:0] f_q; // last fetched entry, ties answers to their cause
  // capture each fetch at its ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_q <= '0;
    end else if (mem_req && mem_ack && !mem_we) begin
      f_q <= mem_rdata;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_fetch;
    mem_req && !mem_we;
  endsequence
  sequence s_wback;
    mem_req && mem_we;
  endsequence
  AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a one cycle answer");
  AST_SET_READ: assert property (pready && !pwrite && paddr == `USB_SET_ADDR
    |-> (prdata & ~`USB_SRC_MASK) == 32'h0) else $error("set register reserved bits");
  AST_EN_READ: assert property (pready && !pwrite && paddr == `USB_ENABLE_ADDR
    |-> (prdata & ~`USB_SRC_MASK) == 32'h0) else $error("enable reserved bits");
  AST_SEL_READ: assert property (pready && !pwrite && paddr == `USB_LINE_SEL_ADDR
    |-> (prdata & ~`USB_SRC_MASK) == 32'h0) else $error("line select reserved bits");
  AST_TOGGLE_READ: assert property (pready && !pwrite && paddr == `USB_TOGGLE_ADDR
    |-> prdata[31:10] == 22'h0) else $error("toggle reserved bits");
  AST_XFER_FETCH: assert property (xfer_req && !xfer_busy |=> s_fetch)
    else $error("packet report did not start a fetch");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack
    |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("memory request dropped");
  AST_ADDR_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("unaligned list word");
  AST_STALL: assert property (resp_valid && resp_code == usb_irq_pkg::RESP_STALL
    |-> !f_q[31] && f_q[29]) else $error("stall without inactive stalled entry");
  AST_DATA: assert property (resp_valid && resp_code == usb_irq_pkg::RESP_DATA
    |-> f_q[31] ##0 s_wback) else $error("data without active entry or write back");
  AST_IGNORE: assert property (resp_valid && resp_code == usb_irq_pkg::RESP_IGNORE
    |-> f_q[30] && !mem_we) else $error("ignored token not disabled or written");
  AST_FIELDS: assert property (resp_valid |-> resp_offset == f_q[15:0]
    && resp_count == f_q[25:16]) else $error("response fields differ from entry");
  AST_WBACK: assert property (s_wback |-> f_q[31] && !mem_wdata[28])
    else $error("write back of inactive entry");
endmodule
bind usb_dev_irq_and_ep_list usb_dev_irq_and_ep_list_properties u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .mem_rdata, .mem_ack, .xfer_req, .xfer_busy, .resp_valid, .resp_code,
  .resp_offset, .resp_count);

// ==== tb/ep_list_mem.sv ====
// system memory model holding the endpoint command/status list
`timescale 1ns/1ps
module ep_list_mem #(parameter int LAT = 3) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] mem [0:31]; // list at base 0, word w=4n+2d+b
  int          cnt;        // wait cycles so far
  logic        gap;        // idle cycle after each ack
  // slow answer; data line churns when not answering
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      cnt       <= 0;
      gap       <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_ack || gap) begin
      mem_ack   <= 1'b0;
      gap       <= mem_ack;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && cnt == LAT) begin
      mem_ack <= 1'b1;
      cnt     <= 0;
      if (mem_we) mem[mem_addr[6:2]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[6:2]];
    end else begin
      cnt       <= mem_req ? cnt + 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ==== tb/usb_dev_irq_and_ep_list_tb.sv ====
// self-checking bench for the usb interrupt and endpoint list block
`timescale 1ns/1ps
`include "usb_irq_map.svh"
module usb_dev_irq_and_ep_list_tb;
  logic        pclk = 1'b0, presetn = 1'b0;          // clock, reset active low
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, mem_rdata, mem_addr, mem_wdata, rd_q;
  logic        pready, pslverr, mem_req, mem_we, mem_ack, xfer_busy, resp_valid, err_q;
  logic        xfer_req = 1'b0, xfer_in = 1'b0, xfer_short = 1'b0;
  logic        sof_event = 1'b0, device_event = 1'b0; // event pulses
  logic [2:0]  xfer_ep = '0;
  logic [9:0]  xfer_len = '0, skip_req = '0, resp_count;
  logic [1:0]  resp_code;
  logic [15:0] resp_offset;
  logic        resp_toggle, resp_buffer, irq_normal, fast_interrupt_line;
  int          fail_count = 0, n_checks = 0;
  always #5 pclk = ~pclk;
  usb_dev_irq_and_ep_list u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .xfer_req, .xfer_ep, .xfer_in, .xfer_len, .xfer_short,
    .skip_req, .sof_event, .device_event, .xfer_busy, .resp_valid, .resp_code,
    .resp_offset, .resp_count, .resp_toggle, .resp_buffer, .irq_normal, .fast_interrupt_line);
  ep_list_mem #(.LAT(3)) u_mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack);
  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [31:0] a, exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp, msg);
  endtask
  // lines settle one cycle after a change; wait two
  task automatic lines(input logic n, f, input string msg);
    repeat (2) @(posedge pclk);
    chk({30'h0, irq_normal, fast_interrupt_line}, {30'h0, n, f}, msg);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 100 && xfer_busy !== 1'b0; n++) @(posedge pclk);
    chk({31'h0, xfer_busy}, 32'h0, "engine idle");
  endtask
  // one packet report, answer judged against the expected entry
  task automatic xfer(input logic [2:0] ep, input logic din, sh, input logic [9:0] len,
                      input logic [1:0] code, input logic [15:0] ofs, input logic [9:0] cnt);
    wait_idle();
    xfer_ep    <= ep;
    xfer_in    <= din;
    xfer_short <= sh;
    xfer_len   <= len;
    xfer_req   <= 1'b1;
    @(posedge pclk);
    xfer_req <= 1'b0;
    for (int n = 0; n < 100 && resp_valid !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, resp_valid}, 32'h1, "response seen");
    chk({30'h0, resp_code}, {30'h0, code}, "response code");
    chk({6'h0, resp_count, resp_offset}, {6'h0, cnt, ofs}, "response fields");
    wait_idle();
  endtask
  task automatic t_reset();
    rd(`USB_ENABLE_ADDR, 32'h0, "enable reset");
    rd(`USB_SET_ADDR, 32'h0, "pending reset");
    rd(`USB_LINE_SEL_ADDR, 32'h0, "select reset");
    rd(`USB_TOGGLE_ADDR, 32'h0, "toggle reset");
    rd(32'h40080030, 32'h0, "unmapped read");
    chk({31'h0, err_q}, 32'h1, "unmapped error");
  endtask
  // enable, set, route, mask and clear interrupt sources
  task automatic t_irq();
    apb(1'b1, `USB_ENABLE_ADDR, 32'h40000008);
    apb(1'b1, `USB_SET_ADDR, 32'h00000028);
    rd(`USB_SET_ADDR, 32'h00000028, "set readback");
    lines(1'b1, 1'b0, "masked and normal");
    apb(1'b1, `USB_LINE_SEL_ADDR, 32'h00000008);
    lines(1'b0, 1'b1, "routed fast");
    sof_event <= 1'b1;
    @(posedge pclk);
    sof_event <= 1'b0;
    lines(1'b1, 1'b1, "frame on normal");
    apb(1'b1, `USB_SET_ADDR, 32'h0);
    rd(`USB_SET_ADDR, 32'h40000028, "zero write keeps");
    apb(1'b1, `USB_PENDING_ADDR, 32'h40000008);
    rd(`USB_SET_ADDR, 32'h00000020, "one clears");
    lines(1'b0, 1'b0, "cleared lines");
    device_event <= 1'b1;
    @(posedge pclk);
    device_event <= 1'b0;
    lines(1'b0, 1'b0, "device masked");
    apb(1'b1, `USB_ENABLE_ADDR, 32'h80000000);
    lines(1'b1, 1'b0, "device unmasked");
    apb(1'b1, `USB_PENDING_ADDR, 32'hffffffff);
    apb(1'b1, `USB_LINE_SEL_ADDR, 32'h0);
  endtask
  // active, stalled, disabled, idle and short entries through the list engine
  task automatic t_list();
    u_mem.mem[0] = 32'h80200000;
    u_mem.mem[2] = 32'h0;
    u_mem.mem[4] = 32'h90400100;
    u_mem.mem[5] = 32'h20000000;
    u_mem.mem[10] = 32'hc0050020;
    apb(1'b1, `USB_LIST_BASE_ADDR, 32'h0);
    xfer(3'd1, 1'b0, 1'b0, 10'd64, usb_irq_pkg::RESP_DATA, 16'h0100, 10'd64);
    chk({30'h0, resp_toggle, resp_buffer}, 32'h0, "toggle and buffer 0");
    chk(u_mem.mem[4] & 32'hf7ffffff, 32'h00000140, "count zero write back");
    rd(`USB_TOGGLE_ADDR, 32'h00000004, "toggle flipped");
    rd(`USB_SET_ADDR, 32'h00000004, "endpoint pending");
    xfer(3'd1, 1'b0, 1'b0, 10'd8, usb_irq_pkg::RESP_STALL, 16'h0, 10'd0);
    chk({31'h0, resp_buffer}, 32'h1, "second buffer");
    xfer(3'd2, 1'b1, 1'b0, 10'd8, usb_irq_pkg::RESP_IGNORE, 16'h0020, 10'd5);
    chk(u_mem.mem[10], 32'hc0050020, "disabled untouched");
    xfer(3'd0, 1'b1, 1'b0, 10'd8, usb_irq_pkg::RESP_NAK, 16'h0, 10'd0);
    xfer(3'd0, 1'b0, 1'b1, 10'd8, usb_irq_pkg::RESP_DATA, 16'h0, 10'd32);
    chk(u_mem.mem[0] & 32'hf7ffffff, 32'h00180008, "short clears active");
  endtask
  // skip pulse deactivates the control in entry
  task automatic t_skip();
    u_mem.mem[2] = 32'h80100000;
    skip_req <= 10'h002;
    @(posedge pclk);
    skip_req <= 10'h000;
    repeat (2) @(posedge pclk);
    wait_idle();
    chk(u_mem.mem[2] & 32'hf7ffffff, 32'h00100000, "skip clears active");
    rd(`USB_SET_ADDR, 32'h00000007, "skip pending");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_irq();
    t_list();
    t_skip();
    conclude();
  end
  // watchdog far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    conclude();
  end
endmodule
